// *** rtl/scan_cfg_regs.svh ***
// Purpose: register offsets, field positions, writable masks and reset value
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes: definitions only
`ifndef SCAN_CFG_REGS_SVH
`define SCAN_CFG_REGS_SVH
`define SC_ADDR_W 12
`define SC_OFF_SCAN_CTRL 12'h000
`define SC_OFF_TIMING 12'h004
`define SC_OFF_PERIPH 12'h008
`define SC_OFF_CMD 12'h010
`define SC_OFF_STATUS 12'h014
`define SC_OFF_DECODER 12'h018
// scan_control fields and writable mask
`define SC_CTRL_MASK 32'h0000_0edf
`define SC_CTRL_MODE_LSB 0
`define SC_CTRL_EVSEL_LSB 2
`define SC_CTRL_CONF_LSB 6
`define SC_CTRL_INV0_BIT 9
`define SC_CTRL_INV1_BIT 10
`define SC_CTRL_ALTEX_BIT 11
// timing_control fields and writable mask
`define SC_TIM_MASK 32'h00cf_f773
`define SC_TIM_FAST_LSB 0
`define SC_TIM_SLOW_LSB 4
`define SC_TIM_PER_LSB 8
`define SC_TIM_TOP_LSB 12
`define SC_TIM_DLY_LSB 22
// peripheral_control fields and writable mask
`define SC_PER_MASK 32'h0cf4_7fff
`define SC_PER_CH0OUT_LSB 6
`define SC_PER_CH1OUT_LSB 8
`define SC_PER_DPRE_LSB 10
`define SC_PER_DREF_BIT 18
`define SC_PER_CMP0_LSB 20
`define SC_PER_CMP1_LSB 22
`define SC_PER_WARM_LSB 26
`define SC_RESET_VALUE 32'h0000_0000
`define SC_CMD_START_BIT 0
`endif

// *** rtl/scan_cfg_pkg.sv ***
// Purpose: types shared by the scan configuration block
// Assumes: nothing
// Notes: constants live in scan_cfg_regs.svh
package scan_cfg_pkg;
   typedef enum logic [1:0] {
      MODE_PERIODIC = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_EVENT = 2'b10,
      MODE_RSVD = 2'b11
   } scan_mode_t;
   typedef enum logic [1:0] {
      CONF_DIRECT = 2'b00,
      CONF_SWAPPED = 2'b01,
      CONF_TOGGLE = 2'b10,
      CONF_DECODER = 2'b11
   } conf_sel_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DELAY = 2'b01,
      ST_SENSE = 2'b10
   } scan_state_t;
   typedef struct packed {
      logic [3:0] input_select;
      logic supply_threshold_en;
      logic input_select_en;
      logic powered;
   } comparator_ctl_t;
   typedef struct packed {
      logic pin_en;
      logic internal_en;
      logic powered;
   } dac_ctl_t;
endpackage : scan_cfg_pkg

// *** rtl/scan_cfg_top.sv ***
// Purpose: scan trigger, timing prescalers and analog control of the sensor scanner
// Assumes: low-frequency and auxiliary clocks arrive as enable pulses on i_ref_clk
// Notes: the sequencer proper lives elsewhere; this block hands it channel and config set
`timescale 1ns/1ns
`default_nettype none
`include "scan_cfg_regs.svh"

// Functional notes
// - selector 0 uses config set equal channel
// - selector 1 swaps sets between halves
// - selector 2 toggles set x, x+8 per trigger
// - selector 3 takes set from decoder state
// - mode 0 scans on period counter overflow
// - mode 1 scans once per start command
// - slow timer clock divided by 2^code
// - fast timer oscillator divided 1,2,4,8
// - warm mode keeps analog parts powered idle
// - comparator1 mode selects controlled inputs
// - comparator0 mode works the same way
// - dac interface clock divided by prescale+1
// - dac1 routing selects pin and internal paths
// - dac0 codes 0 and 1 routing
// - dac0 codes 2 and 3 routing
module scan_cfg_top #(
   parameter int CHANNELS = 16
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [`SC_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_low_freq_tick,
   input wire logic i_aux_fast_tick,
   input wire logic [7:0] i_event_channel,
   input wire logic [3:0] i_decoder_state,
   input wire logic i_comparator0_raw,
   input wire logic i_comparator1_raw,
   output logic o_comparator0_eval,
   output logic o_comparator1_eval,
   output logic o_scan_start,
   output logic o_scan_busy,
   output logic [3:0] o_channel,
   output logic [3:0] o_config_set,
   output logic o_slow_timer_tick,
   output logic o_fast_timer_tick,
   output logic o_dac_clk_tick,
   output logic o_alt_excite_to_comparator,
   output scan_cfg_pkg::comparator_ctl_t o_comparator0_ctl,
   output scan_cfg_pkg::comparator_ctl_t o_comparator1_ctl,
   output scan_cfg_pkg::dac_ctl_t o_dac0_ctl,
   output scan_cfg_pkg::dac_ctl_t o_dac1_ctl,
   output logic o_dac_reference_select
);
   import scan_cfg_pkg::*;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic div_hit(input logic [6:0] cnt, input logic [2:0] code);
      logic [6:0] mask;
      mask = 7'((8'h01 << code) - 8'h01);
      div_hit = ((cnt & mask) == mask);
   endfunction : div_hit

   function automatic comparator_ctl_t cmp_ctl(input logic [1:0] mode, input logic pwr,
                                               input logic [3:0] chan);
      comparator_ctl_t c;
      c.input_select = chan;
      c.input_select_en = (mode == 2'h1) || (mode == 2'h2);
      c.supply_threshold_en = (mode == 2'h2);
      c.powered = pwr;
      cmp_ctl = c;
   endfunction : cmp_ctl

   function automatic dac_ctl_t dac_route(input logic [1:0] code, input logic pwr);
      dac_ctl_t d;
      d.pin_en = code[0];
      d.internal_en = code[1];
      d.powered = pwr;
      dac_route = d;
   endfunction : dac_route

   // ************************************************************
   // registers
   // ************************************************************
   logic [31:0] scan_control_reg;
   logic [31:0] timing_control_reg;
   logic [31:0] peripheral_control_reg;
   logic start_cmd;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         scan_control_reg <= `SC_RESET_VALUE;
         timing_control_reg <= `SC_RESET_VALUE;
         peripheral_control_reg <= `SC_RESET_VALUE;
      end else if (i_wr) begin
         // reserved bits are masked off so they always read zero
         if (i_addr == `SC_OFF_SCAN_CTRL) begin
            scan_control_reg <= i_wdata & `SC_CTRL_MASK;
         end else if (i_addr == `SC_OFF_TIMING) begin
            timing_control_reg <= i_wdata & `SC_TIM_MASK;
         end else if (i_addr == `SC_OFF_PERIPH) begin
            peripheral_control_reg <= i_wdata & `SC_PER_MASK;
         end
      end
   end

   assign start_cmd = i_wr && (i_addr == `SC_OFF_CMD) && i_wdata[`SC_CMD_START_BIT];

   scan_mode_t scan_trigger_mode;
   conf_sel_t scan_config_select;
   logic [2:0] scan_start_event_select;
   logic [1:0] start_delay;
   logic [7:0] period_top;
   logic [2:0] period_prescale;
   logic [2:0] slow_timer_prescale;
   logic [1:0] fast_timer_prescale;
   logic [1:0] analog_warm_mode;
   logic [4:0] dac_prescale;
   assign scan_trigger_mode = scan_mode_t'(scan_control_reg[`SC_CTRL_MODE_LSB +: 2]);
   assign scan_start_event_select = scan_control_reg[`SC_CTRL_EVSEL_LSB +: 3];
   assign scan_config_select = conf_sel_t'(scan_control_reg[`SC_CTRL_CONF_LSB +: 2]);
   assign fast_timer_prescale = timing_control_reg[`SC_TIM_FAST_LSB +: 2];
   assign slow_timer_prescale = timing_control_reg[`SC_TIM_SLOW_LSB +: 3];
   assign period_prescale = timing_control_reg[`SC_TIM_PER_LSB +: 3];
   assign period_top = timing_control_reg[`SC_TIM_TOP_LSB +: 8];
   assign start_delay = timing_control_reg[`SC_TIM_DLY_LSB +: 2];
   assign dac_prescale = peripheral_control_reg[`SC_PER_DPRE_LSB +: 5];
   assign analog_warm_mode = peripheral_control_reg[`SC_PER_WARM_LSB +: 2];

   // ************************************************************
   // prescalers
   // ************************************************************
   logic [6:0] slow_div_reg;
   logic [2:0] fast_div_reg;
   logic [4:0] dac_div_reg;

   // one free-running divider serves both slow-clock consumers
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         slow_div_reg <= 7'h00;
      end else if (i_low_freq_tick) begin
         slow_div_reg <= slow_div_reg + 7'h01;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         fast_div_reg <= 3'h0;
      end else if (i_aux_fast_tick) begin
         fast_div_reg <= fast_div_reg + 3'h1;
      end
   end

   logic dac_hit;
   assign dac_hit = (dac_div_reg >= dac_prescale);
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         dac_div_reg <= 5'h00;
      end else if (i_aux_fast_tick) begin
         dac_div_reg <= dac_hit ? 5'h00 : dac_div_reg + 5'h01;
      end
   end

   logic period_tick;
   assign period_tick = i_low_freq_tick && div_hit(slow_div_reg, period_prescale);
   assign o_slow_timer_tick = i_low_freq_tick && div_hit(slow_div_reg, slow_timer_prescale);
   assign o_fast_timer_tick = i_aux_fast_tick &&
                              div_hit({4'h0, fast_div_reg}, {1'b0, fast_timer_prescale});
   assign o_dac_clk_tick = i_aux_fast_tick && dac_hit;

   // ************************************************************
   // period counter and scan triggers
   // ************************************************************
   logic [7:0] period_cnt_reg;
   logic period_overflow;
   assign period_overflow = period_tick && (period_cnt_reg >= period_top);
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         period_cnt_reg <= 8'h00;
      end else if (period_tick) begin
         period_cnt_reg <= period_overflow ? 8'h00 : period_cnt_reg + 8'h01;
      end
   end

   logic [7:0] event_prev_reg;
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         event_prev_reg <= 8'h00;
      end else begin
         event_prev_reg <= i_event_channel;
      end
   end

   logic trigger;
   always_comb begin
      case (scan_trigger_mode)
         MODE_PERIODIC: trigger = period_overflow;
         MODE_SINGLE: trigger = start_cmd;
         MODE_EVENT: trigger = i_event_channel[scan_start_event_select] &&
                               !event_prev_reg[scan_start_event_select];
         default: trigger = 1'b0;
      endcase
   end

   // ************************************************************
   // scan sequence
   // ************************************************************
   scan_state_t state_reg;
   logic [3:0] chan_reg;
   logic [1:0] delay_reg;
   logic [15:0] toggle_reg;

   // a trigger while busy is dropped; scans never overlap
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
         chan_reg <= 4'h0;
         delay_reg <= 2'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (trigger) begin
                  chan_reg <= 4'h0;
                  delay_reg <= start_delay;
                  state_reg <= ST_DELAY;
               end
            end
            ST_DELAY: begin
               if (delay_reg == 2'h0) begin
                  state_reg <= ST_SENSE;
               end else if (i_low_freq_tick) begin
                  delay_reg <= delay_reg - 2'h1;
               end
            end
            ST_SENSE: begin
               if (i_low_freq_tick) begin
                  if (chan_reg == 4'(CHANNELS - 1)) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     chan_reg <= chan_reg + 4'h1;
                     delay_reg <= start_delay;
                     state_reg <= ST_DELAY;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   logic chan_done;
   assign chan_done = (state_reg == ST_SENSE) && i_low_freq_tick;
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         toggle_reg <= 16'h0000;
      end else if (chan_done && scan_config_select == CONF_TOGGLE) begin
         toggle_reg[chan_reg] <= !toggle_reg[chan_reg];
      end
   end

   logic [3:0] conf_next;
   always_comb begin
      case (scan_config_select)
         CONF_DIRECT: conf_next = chan_reg;
         CONF_SWAPPED: conf_next = {!chan_reg[3], chan_reg[2:0]};
         CONF_TOGGLE: conf_next = {chan_reg[3] ^ toggle_reg[chan_reg], chan_reg[2:0]};
         default: conf_next = i_decoder_state;
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_channel <= 4'h0;
         o_config_set <= 4'h0;
         o_scan_start <= 1'b0;
         o_scan_busy <= 1'b0;
      end else begin
         o_channel <= chan_reg;
         o_config_set <= conf_next;
         o_scan_start <= (state_reg == ST_IDLE) && trigger;
         o_scan_busy <= (state_reg != ST_IDLE);
      end
   end

   // ************************************************************
   // analog control
   // ************************************************************
   logic active;
   logic cmp_pwr;
   logic dac_pwr;
   assign active = (state_reg != ST_IDLE);
   assign cmp_pwr = active || analog_warm_mode[0];
   assign dac_pwr = active || analog_warm_mode[1];

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_comparator0_ctl <= '0;
         o_comparator1_ctl <= '0;
         o_dac0_ctl <= '0;
         o_dac1_ctl <= '0;
         o_dac_reference_select <= 1'b0;
         o_alt_excite_to_comparator <= 1'b0;
         o_comparator0_eval <= 1'b0;
         o_comparator1_eval <= 1'b0;
      end else begin
         o_comparator0_ctl <= cmp_ctl(peripheral_control_reg[`SC_PER_CMP0_LSB +: 2], cmp_pwr,
                                      chan_reg);
         o_comparator1_ctl <= cmp_ctl(peripheral_control_reg[`SC_PER_CMP1_LSB +: 2], cmp_pwr,
                                      chan_reg);
         o_dac0_ctl <= dac_route(peripheral_control_reg[`SC_PER_CH0OUT_LSB +: 2],
                                 dac_pwr);
         o_dac1_ctl <= dac_route(peripheral_control_reg[`SC_PER_CH1OUT_LSB +: 2],
                                 dac_pwr);
         // the flag is passed through; choosing it right is up to software
         o_dac_reference_select <= peripheral_control_reg[`SC_PER_DREF_BIT];
         o_alt_excite_to_comparator <= scan_control_reg[`SC_CTRL_ALTEX_BIT];
         o_comparator0_eval <= i_comparator0_raw ^ scan_control_reg[`SC_CTRL_INV0_BIT];
         o_comparator1_eval <= i_comparator1_raw ^ scan_control_reg[`SC_CTRL_INV1_BIT];
      end
   end

   // ************************************************************
   // read port
   // ************************************************************
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         if (i_addr == `SC_OFF_SCAN_CTRL) begin
            o_rdata <= scan_control_reg;
         end else if (i_addr == `SC_OFF_TIMING) begin
            o_rdata <= timing_control_reg;
         end else if (i_addr == `SC_OFF_PERIPH) begin
            o_rdata <= peripheral_control_reg;
         end else if (i_addr == `SC_OFF_STATUS) begin
            o_rdata <= {16'h0000, period_cnt_reg, conf_next, chan_reg[2:0], active};
         end else begin
            o_rdata <= 32'h0000_0000;
         end
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end
endmodule : scan_cfg_top
`default_nettype wire

// *** tb/scan_cfg_checker.sv ***
// Purpose: port assertions for the scan configuration block
// Assumes: register shadows follow the writes seen at the port
// Notes: bound to scan_cfg_top below the module
`timescale 1ns/1ns
`default_nettype none
`include "scan_cfg_regs.svh"
module scan_cfg_checker (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [`SC_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_low_freq_tick,
   input wire logic i_comparator0_raw,
   input wire logic i_comparator1_raw,
   input wire logic o_comparator0_eval,
   input wire logic o_comparator1_eval,
   input wire logic o_scan_start,
   input wire logic o_scan_busy,
   input wire logic [3:0] o_channel,
   input wire logic [3:0] o_config_set,
   input wire logic o_slow_timer_tick,
   input wire logic o_alt_excite_to_comparator,
   input wire scan_cfg_pkg::comparator_ctl_t o_comparator0_ctl,
   input wire scan_cfg_pkg::dac_ctl_t o_dac0_ctl,
   input wire scan_cfg_pkg::dac_ctl_t o_dac1_ctl
);
   import scan_cfg_pkg::*;
   logic [31:0] ctl_q, tim_q, per_q;
   logic [1:0] up_q;
   logic armed;
   assign armed = (up_q == 2'h3);
   // outputs are held low one edge past reset, so the armed checks wait three edges
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ctl_q <= 32'h0;
         tim_q <= 32'h0;
         per_q <= 32'h0;
         up_q <= 2'h0;
      end else begin
         up_q <= up_q + {1'b0, up_q != 2'h3};
         if (i_wr && i_addr == `SC_OFF_SCAN_CTRL) ctl_q <= i_wdata & `SC_CTRL_MASK;
         if (i_wr && i_addr == `SC_OFF_TIMING) tim_q <= i_wdata & `SC_TIM_MASK;
         if (i_wr && i_addr == `SC_OFF_PERIPH) per_q <= i_wdata & `SC_PER_MASK;
      end
   end
   // ****************
   // assertions
   // ****************
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);
   sequence s_begin;
      o_scan_start;
   endsequence
   sequence s_run;
      ##[0:2] o_scan_busy;
   endsequence
   AST_START_RUN: assert property (s_begin |-> s_run)
      else $error("scan start without busy");
   AST_START_ONE: assert property (o_scan_start |=> !o_scan_start)
      else $error("start pulse too long");
   AST_EVAL0: assert property (armed |->
      o_comparator0_eval == ($past(i_comparator0_raw) ^ $past(ctl_q[9])))
      else $error("comparator0 eval wrong");
   AST_EVAL1: assert property (armed |->
      o_comparator1_eval == ($past(i_comparator1_raw) ^ $past(ctl_q[10])))
      else $error("comparator1 eval wrong");
   AST_ALT_MAP: assert property (armed && $stable(ctl_q) |->
      o_alt_excite_to_comparator == ctl_q[11]) else $error("alt map wrong");
   AST_CONF_DIRECT: assert property (o_scan_busy && $stable(o_channel) &&
      $stable(ctl_q) && ctl_q[7:6] == 2'h0 |-> o_config_set == o_channel)
      else $error("direct config set wrong");
   AST_CONF_SWAP: assert property (o_scan_busy && $stable(o_channel) &&
      $stable(ctl_q) && ctl_q[7:6] == 2'h1 |-> o_config_set == (o_channel ^ 4'h8))
      else $error("swapped config set wrong");
   AST_SLOW_DIV1: assert property (armed && $stable(tim_q) && tim_q[6:4] == 3'h0
      |-> o_slow_timer_tick == i_low_freq_tick) else $error("slow tick wrong");
   AST_CMP0_MODE: assert property (armed && $stable(per_q) && per_q[21:20] != 2'h3
      |-> o_comparator0_ctl.input_select_en == (per_q[21:20] != 2'h0)
      && o_comparator0_ctl.supply_threshold_en == per_q[21]) else $error("cmp0 mode wrong");
   AST_DAC0_ROUTE: assert property (armed && $stable(per_q) |->
      o_dac0_ctl.pin_en == per_q[6] && o_dac0_ctl.internal_en == per_q[7])
      else $error("dac0 routing wrong");
   AST_DAC1_ROUTE: assert property (armed && $stable(per_q) |->
      o_dac1_ctl.pin_en == per_q[8] && o_dac1_ctl.internal_en == per_q[9])
      else $error("dac1 routing wrong");
   AST_WARM: assert property (armed && $stable(per_q) |->
      (!per_q[26] || o_comparator0_ctl.powered) && (!per_q[27] || o_dac1_ctl.powered))
      else $error("warm power wrong");
endmodule : scan_cfg_checker
bind scan_cfg_top scan_cfg_checker i_scan_cfg_checker (.i_ref_clk, .i_rst, .i_addr,
   .i_wdata, .i_wr, .i_low_freq_tick, .i_comparator0_raw, .i_comparator1_raw,
   .o_comparator0_eval, .o_comparator1_eval, .o_scan_start, .o_scan_busy, .o_channel,
   .o_config_set, .o_slow_timer_tick, .o_alt_excite_to_comparator, .o_comparator0_ctl,
   .o_dac0_ctl, .o_dac1_ctl);
`default_nettype wire

// *** tb/analog_far_side.sv ***
// Purpose: far-side model of the two analog comparators
// Assumes: a comparator output means something only while powered
// Notes: unpowered outputs flip every cycle so a stale level never looks valid
`timescale 1ns/1ns
`default_nettype none
module analog_far_side (
   input wire logic i_ref_clk,
   input wire scan_cfg_pkg::comparator_ctl_t i_cmp0_ctl,
   input wire scan_cfg_pkg::comparator_ctl_t i_cmp1_ctl,
   output logic o_raw0,
   output logic o_raw1
);
   import scan_cfg_pkg::*;
   logic [7:0] lfsr_reg = 8'h5a;
   logic raw0_reg = 1'b0;
   logic raw1_reg = 1'b0;
   assign o_raw0 = raw0_reg;
   assign o_raw1 = raw1_reg;
   always @(posedge i_ref_clk) begin
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      raw0_reg <= i_cmp0_ctl.powered ? lfsr_reg[0] : ~raw0_reg;
      raw1_reg <= i_cmp1_ctl.powered ? lfsr_reg[4] : ~raw1_reg;
   end
endmodule : analog_far_side
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: self-checking bench for scan_cfg_top
// Assumes: ticks are one-cycle enables, start delay counted in low ticks
// Notes: random stimulus from a fixed seed
`timescale 1ns/1ns
`default_nettype none
`include "scan_cfg_regs.svh"
module testbench;
   import scan_cfg_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, lf = 1'b0, ax = 1'b0;
   logic [11:0] addr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic [7:0] ev = 8'h0;
   logic [3:0] dec = 4'h0;
   logic [31:0] rdata;
   logic raw0, raw1, st, busy, slow, fast, dclk, alt, dref;
   logic [3:0] chan, cset;
   logic [3:0] seen [16];
   comparator_ctl_t c0, c1;
   dac_ctl_t d0, d1;
   int ns = 0, nf = 0, nd = 0, nst = 0, num_errors = 0, cmp_count = 0;
   scan_cfg_top i_scan_cfg_top (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_low_freq_tick(lf), .i_aux_fast_tick(ax),
      .i_event_channel(ev), .i_decoder_state(dec), .i_comparator0_raw(raw0),
      .i_comparator1_raw(raw1), .o_comparator0_eval(), .o_comparator1_eval(),
      .o_scan_start(st), .o_scan_busy(busy), .o_channel(chan), .o_config_set(cset),
      .o_slow_timer_tick(slow), .o_fast_timer_tick(fast), .o_dac_clk_tick(dclk),
      .o_alt_excite_to_comparator(alt), .o_comparator0_ctl(c0), .o_comparator1_ctl(c1),
      .o_dac0_ctl(d0), .o_dac1_ctl(d1), .o_dac_reference_select(dref));
   analog_far_side i_analog_far_side (.i_ref_clk(clk), .i_cmp0_ctl(c0), .i_cmp1_ctl(c1),
      .o_raw0(raw0), .o_raw1(raw1));
   initial forever #10 clk = ~clk;
   always @(posedge clk) begin
      ns <= ns + int'(slow === 1'b1);
      nf <= nf + int'(fast === 1'b1);
      nd <= nd + int'(dclk === 1'b1);
      nst <= nst + int'(st === 1'b1);
      if (busy === 1'b1 && lf === 1'b1) seen[chan] <= cset;
   end
   // ****************
   // tasks
   // ****************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wreg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check("read data", exp, rdata);
   endtask : rchk
   // both timers see the same tick so one window serves every divider
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         lf <= 1'b1;
         ax <= 1'b1;
         @(posedge clk);
         lf <= 1'b0;
         ax <= 1'b0;
         @(posedge clk);
      end
      #1;
   endtask : tick
   task automatic idle();
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 100) begin
         tick(1);
         k++;
      end
      check("scan end", 32'h0, {31'h0, busy});
   endtask : idle
   task automatic pulse(input logic [7:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 8'h0;
      repeat (4) @(posedge clk);
      #1;
   endtask : pulse
   function automatic logic [3:0] f_conf(input int sel, input logic [3:0] ch, input int pass);
      case (sel)
         0: return ch;
         1: return ch ^ 4'h8;
         2: return ch ^ {pass[0], 3'h0};
         default: return dec;
      endcase
   endfunction : f_conf
   task automatic final_report();
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   initial begin
      #1_000_000;
      num_errors++;
      final_report();
   end
   initial begin
      logic [31:0] v;
      int d, k, n0, a, b, e, p, t, pp, sel;
      void'($urandom(32'h9a0c));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rchk(`SC_OFF_SCAN_CTRL, 32'h0);
      rchk(`SC_OFF_TIMING, 32'h0);
      rchk(`SC_OFF_PERIPH, 32'h0);
      rchk(12'h0fc, 32'h0);
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         wreg(`SC_OFF_SCAN_CTRL, v);
         wreg(`SC_OFF_TIMING, v);
         wreg(`SC_OFF_PERIPH, v);
         wreg(12'h0fc, ~v);
         rchk(`SC_OFF_SCAN_CTRL, v & `SC_CTRL_MASK);
         rchk(`SC_OFF_TIMING, v & `SC_TIM_MASK);
         rchk(`SC_OFF_PERIPH, v & `SC_PER_MASK);
         check("dac reference", v[18], dref);
         check("alt map", v[11], alt);
      end
      wreg(`SC_OFF_SCAN_CTRL, 32'h1);
      idle();
      for (int c = 0; c < 4; c++) begin
         k = c % 3;
         wreg(`SC_OFF_PERIPH, c << 26 | k << 22 | k << 20 | c << 8 | c << 6);
         tick(1);
         check("analog ctl", {c[0], c[1], c[0], c[1], k != 0, k == 2, c[0], c[1]}, {d0.pin_en,
            d0.internal_en, d1.pin_en, d1.internal_en, c1.input_select_en,
            c1.supply_threshold_en, c0.powered, d0.powered});
      end
      for (int c = 0; c < 8; c++) begin
         p = (1 << ($urandom % 6)) - 1;
         wreg(`SC_OFF_TIMING, c << 4 | c % 4);
         wreg(`SC_OFF_PERIPH, p << 10);
         tick(32);
         a = ns;
         b = nf;
         e = nd;
         tick(128);
         check("slow ticks", 128 >> c, ns - a);
         check("fast ticks", 128 >> (c % 4), nf - b);
         check("dac ticks", 128 / (p + 1), nd - e);
      end
      for (int s = 0; s < 5; s++) begin
         sel = (s < 3) ? s : s - 1;
         d = $urandom % 4;
         wreg(`SC_OFF_TIMING, d << 22);
         wreg(`SC_OFF_SCAN_CTRL, sel << 6 | 1);
         idle();
         dec <= 4'($urandom);
         n0 = nst;
         wreg(`SC_OFF_CMD, 32'h1);
         k = 0;
         while (busy !== 1'b1 && k < 10) begin
            @(posedge clk);
            #1;
            k++;
         end
         k = 0;
         while (busy === 1'b1 && k < 100) begin
            tick(1);
            k++;
         end
         check("scan ticks", 16 * (d + 1), k);
         tick(4);
         check("single starts", 1, nst - n0);
         for (int c = 0; c < 16; c++) begin
            check("config set", f_conf(sel, c, s - 2), seen[c]);
         end
      end
      wreg(`SC_OFF_TIMING, 32'h0);
      for (int c = 0; c < 8; c++) begin
         wreg(`SC_OFF_SCAN_CTRL, c << 2 | 2);
         n0 = nst;
         pulse(8'h1 << ((c + 1) % 8));
         pulse(8'h1 << c);
         check("event starts", 1, nst - n0);
         idle();
      end
      // mode 3 must ignore both the command and the overflow of a zero top
      wreg(`SC_OFF_SCAN_CTRL, 32'h3);
      n0 = nst;
      wreg(`SC_OFF_CMD, 32'h1);
      tick(2);
      check("reserved mode starts", 0, nst - n0);
      t = 1 + $urandom % 7;
      pp = $urandom % 3;
      wreg(`SC_OFF_TIMING, t << 12 | pp << 8);
      wreg(`SC_OFF_SCAN_CTRL, 32'h0);
      n0 = nst;
      k = 0;
      while (nst == n0 && k < 200) begin
         tick(1);
         k++;
      end
      check("period wait", 1, k > (t << pp) && k <= ((t + 1) << pp));
      final_report();
   end
endmodule : testbench
`default_nettype wire
